//--- design/led_status_pkg.sv
// Package with constants and types for the light curtain LED status indicator
// Behaviour
// - No beam synchronised: all eight diagnostic LEDs off
// - One beam synchronised, poor alignment: only LED 1 blue of LEDs 1-4
// - Insufficient signal for stable availability: LEDs 1 and 2 blue
// - Good alignment, stable availability: LEDs 1 to 3 blue
// - Very good alignment: LEDs 1 to 4 blue
// - Topmost beam synchronised: LEDs 5 and 6 blue
// - Bottommost beam synchronised: LEDs 7 and 8 blue
// - Feedback warning with monitoring set: flash LED 1, quality on 2 to 4
// - Reset button fault: flash LED 4, quality on LEDs 1 to 3
// - Contamination rise, alignment aid on, or alignment over 3 s: show quality again
// - Aligned with field clear: quality display off after fixed delay
// - Cabled sender mirrors receiver; sender state follows switching-output LED
// - Uncabled sender, running without fault: state LED yellow
// - Configuration shown white on LEDs 1, 3 and 4
// - Factory reset active: red output LED, yellow/green field, diagnostics off
// - Configuration mode after change: red output LED, flashing green field
// - Alignment aid on, field clear: red output LED, green field LED
// - Field interrupted or reset just pressed: red output LED, red field LED
// - Field clear, reset required: red output LED, yellow field LED
// - Reset button defective or held: flash LED 4 yellow
// - Feedback input without signal: red output LED, flash LED 1; power cycle clears
// - At power-up all LEDs light briefly before configuration indications
package led_status_pkg;

   // LED colour codes
   typedef enum logic [2:0]
   {
      LED_OFF,
      LED_BLUE,
      LED_WHITE,
      LED_RED,
      LED_GREEN,
      LED_YELLOW,
      LED_YELLOW_GREEN
   } led_colour_type;

   // One LED: colour and flash flag
   typedef struct packed
   {
      led_colour_type colour;
      logic           flash;
   } led_type;

   // Alignment quality levels from the optics
   localparam logic [2:0] QUALITY_NONE      = 3'h0;
   localparam logic [2:0] QUALITY_SYNC      = 3'h1;
   localparam logic [2:0] QUALITY_WEAK      = 3'h2;
   localparam logic [2:0] QUALITY_GOOD      = 3'h3;
   localparam logic [2:0] QUALITY_VERY_GOOD = 3'h4;

   // Inputs describing the receiver state
   typedef struct packed
   {
      logic [2:0] quality;
      logic       top_sync;
      logic       bottom_sync;
      logic       field_clear;
      logic       reset_required;
      logic       reset_pressed;
      logic       reset_button_fault;
      logic       feedback_warning;
      logic       contamination_rise;
      logic       alignment_aid_on;
      logic       output_on;
      logic       config_mode;
      logic       factory_reset;
   } status_type;

   // Configured options
   typedef struct packed
   {
      logic feedback_enabled;
      logic beam_code_set;
      logic restart_interlock;
   } config_type;

   // Timing in milliseconds and derived cycles at 40 MHz
   localparam int unsigned CLOCK_KHZ          = 40000;
   localparam int unsigned ALIGN_LONG_MS      = 3000;
   localparam int unsigned ALIGN_LONG_CYCLES  = ALIGN_LONG_MS * CLOCK_KHZ;
   localparam int unsigned FLASH_HALF_CYCLES  = 8000000;
   localparam int unsigned DISPLAY_OFF_CYCLES = 400000000;
   localparam int unsigned LAMP_TEST_CYCLES   = 20000000;
   localparam int unsigned CONFIG_SHOW_CYCLES = 80000000;

   localparam logic [31:0] COUNT_ZERO = 32'h0;

endpackage : led_status_pkg

//--- design/flash_timer.sv
// Free running flash cadence generator
`timescale 1ns/1ps
module flash_timer
#(
   parameter int unsigned HALF_CYCLES = led_status_pkg::FLASH_HALF_CYCLES
)
(
   input  wire logic clock,
   input  wire logic srst,
   output logic      phase
);

   logic [31:0] count_q;

   // Toggle phase every half period
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         count_q <= led_status_pkg::COUNT_ZERO;
         phase   <= 1'b0;
      end
      else if (count_q >= HALF_CYCLES - 1)
      begin
         count_q <= led_status_pkg::COUNT_ZERO;
         phase   <= ~phase;
      end
      else
      begin
         count_q <= count_q + 32'h1;
      end
   end

endmodule : flash_timer

//--- design/event_timer.sv
// Retriggerable one-shot timer: counts up while held, expired once cycles reached
`timescale 1ns/1ps
module event_timer
(
   input  wire logic        clock,
   input  wire logic        srst,
   input  wire logic        start,
   input  wire logic        hold,
   input  wire logic [31:0] cycles,
   output logic             expired
);

   logic [31:0] count_q;

   // Restart on start, clear on hold release, count while held
   always_ff @(posedge clock)
   begin
      if (srst || start || !hold)
      begin
         count_q <= led_status_pkg::COUNT_ZERO;
         expired <= 1'b0;
      end
      else if (count_q >= cycles - 32'h1)
      begin
         expired <= 1'b1;
      end
      else
      begin
         count_q <= count_q + 32'h1;
      end
   end

endmodule : event_timer

//--- design/led_status_indicator.sv
// Top level: LED status decoding for receiver and mirrored sender
`timescale 1ns/1ps
module led_status_indicator
#(
   parameter int unsigned FLASH_HALF  = led_status_pkg::FLASH_HALF_CYCLES,
   parameter int unsigned DISPLAY_OFF = led_status_pkg::DISPLAY_OFF_CYCLES,
   parameter int unsigned ALIGN_LONG  = led_status_pkg::ALIGN_LONG_CYCLES,
   parameter int unsigned LAMP_TEST   = led_status_pkg::LAMP_TEST_CYCLES,
   parameter int unsigned CONFIG_SHOW = led_status_pkg::CONFIG_SHOW_CYCLES
)
(
   input  wire logic                        clock,
   input  wire logic                        srst,
   input  wire led_status_pkg::status_type  status,
   input  wire led_status_pkg::config_type  config_set,
   input  wire logic                        sender_cabled,
   input  wire logic                        sender_running,
   input  wire logic                        sender_fault,
   output led_status_pkg::led_type [7:0]    diag_led,
   output led_status_pkg::led_type          output_led,
   output led_status_pkg::led_type          field_led,
   output led_status_pkg::led_type [7:0]    sender_diag_led,
   output led_status_pkg::led_type          sender_state_led,
   output led_status_pkg::led_type          sender_field_led
);

   typedef enum logic [1:0]
   {
      PHASE_LAMP_TEST,
      PHASE_CONFIG,
      PHASE_RUN
   } phase_type;

   phase_type   phase_q;
   logic [31:0] phase_count_q;
   logic        flash_phase;
   logic        quality_show_q;
   logic        aid_prev_q;
   logic        contam_prev_q;
   logic        field_clear_prev_q;
   logic        align_long_q;
   logic        display_timeout;
   logic [31:0] align_count_q;
   logic        aligned_clear;
   logic        retrigger;

   led_status_pkg::led_type [7:0] diag_d;
   led_status_pkg::led_type       output_d;
   led_status_pkg::led_type       field_d;
   led_status_pkg::led_type       state_d;

   // Build one LED value
   function automatic led_status_pkg::led_type make_led
   (
      input led_status_pkg::led_colour_type colour,
      input logic                           flash
   );
      led_status_pkg::led_type led;
      led.colour = colour;
      led.flash  = flash;
      return led;
   endfunction : make_led

   // Quality LED n (1..4) lit for the given level
   function automatic logic quality_lit
   (
      input logic [2:0] quality,
      input int unsigned index
   );
      logic [2:0] needed;
      needed = 3'(index);
      return quality >= needed;
   endfunction : quality_lit

   flash_timer
   #(
      .HALF_CYCLES (FLASH_HALF)
   )
   u_flash
   (
      .clock (clock),
      .srst  (srst),
      .phase (flash_phase)
   );

   // Aligned with field clear: field clear and quality QUALITY_GOOD or better
   assign aligned_clear = status.field_clear
                        && (status.quality >= led_status_pkg::QUALITY_GOOD);

   // Rising contamination, aid switch-on or long alignment reopen the display
   assign retrigger = (status.contamination_rise && !contam_prev_q)
                    || (status.alignment_aid_on && !aid_prev_q)
                    || align_long_q;

   event_timer u_display_timer
   (
      .clock   (clock),
      .srst    (srst),
      .start   (retrigger),
      .hold    (aligned_clear),
      .cycles  (DISPLAY_OFF),
      .expired (display_timeout)
   );

   // Power-up lamp test, then configuration, then run
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         phase_q       <= PHASE_LAMP_TEST;
         phase_count_q <= led_status_pkg::COUNT_ZERO;
      end
      else
      begin
         case (phase_q)
            PHASE_LAMP_TEST:
            begin
               if (phase_count_q >= LAMP_TEST - 1)
               begin
                  phase_q       <= PHASE_CONFIG;
                  phase_count_q <= led_status_pkg::COUNT_ZERO;
               end
               else
               begin
                  phase_count_q <= phase_count_q + 32'h1;
               end
            end
            PHASE_CONFIG:
            begin
               if (phase_count_q >= CONFIG_SHOW - 1)
               begin
                  phase_q       <= PHASE_RUN;
                  phase_count_q <= led_status_pkg::COUNT_ZERO;
               end
               else
               begin
                  phase_count_q <= phase_count_q + 32'h1;
               end
            end
            PHASE_RUN:
            begin
               phase_count_q <= led_status_pkg::COUNT_ZERO;
            end
            default:
            begin
               phase_q <= PHASE_LAMP_TEST;
            end
         endcase
      end
   end

   // Edge history for retrigger events
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         aid_prev_q         <= 1'b0;
         contam_prev_q      <= 1'b0;
         field_clear_prev_q <= 1'b0;
      end
      else
      begin
         aid_prev_q         <= status.alignment_aid_on;
         contam_prev_q      <= status.contamination_rise;
         field_clear_prev_q <= aligned_clear;
      end
   end

   // Alignment not yet complete for over 3 s: pulse once per period
   always_ff @(posedge clock)
   begin
      if (srst || aligned_clear)
      begin
         align_count_q <= led_status_pkg::COUNT_ZERO;
         align_long_q  <= 1'b0;
      end
      else if (align_count_q >= ALIGN_LONG - 1)
      begin
         align_count_q <= led_status_pkg::COUNT_ZERO;
         align_long_q  <= 1'b1;
      end
      else
      begin
         align_count_q <= align_count_q + 32'h1;
         align_long_q  <= 1'b0;
      end
   end

   // Quality display on unless timed out while aligned and clear
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         quality_show_q <= 1'b1;
      end
      else if (retrigger || !aligned_clear)
      begin
         quality_show_q <= 1'b1;
      end
      else if (display_timeout)
      begin
         quality_show_q <= 1'b0;
      end
   end

   // Receiver indication decode; later checks take priority
   always_comb
   begin
      diag_d   = '{default: make_led(led_status_pkg::LED_OFF, 1'b0)};
      output_d = make_led(led_status_pkg::LED_GREEN, 1'b0);
      field_d  = make_led(led_status_pkg::LED_GREEN, 1'b0);

      if (phase_q == PHASE_LAMP_TEST)
      begin
         // Every LED lit white for the lamp test
         diag_d   = '{default: make_led(led_status_pkg::LED_WHITE, 1'b0)};
         output_d = make_led(led_status_pkg::LED_WHITE, 1'b0);
         field_d  = make_led(led_status_pkg::LED_WHITE, 1'b0);
      end
      else
      begin
         if (!status.output_on)
         begin
            output_d = make_led(led_status_pkg::LED_RED, 1'b0);
         end

         // Field LED, most specific condition last
         if (!status.field_clear || status.reset_pressed)
         begin
            field_d = make_led(led_status_pkg::LED_RED, 1'b0);
         end
         else if (status.reset_required)
         begin
            field_d = make_led(led_status_pkg::LED_YELLOW, 1'b0);
         end
         if (status.alignment_aid_on && status.field_clear)
         begin
            output_d = make_led(led_status_pkg::LED_RED, 1'b0);
            field_d  = make_led(led_status_pkg::LED_GREEN, 1'b0);
         end

         if (phase_q == PHASE_CONFIG)
         begin
            // Configuration in white
            if (config_set.feedback_enabled)
            begin
               diag_d[0] = make_led(led_status_pkg::LED_WHITE, 1'b0);
            end
            if (config_set.beam_code_set)
            begin
               diag_d[2] = make_led(led_status_pkg::LED_WHITE, 1'b0);
            end
            if (config_set.restart_interlock)
            begin
               diag_d[3] = make_led(led_status_pkg::LED_WHITE, 1'b0);
            end
         end
         else if (quality_show_q)
         begin
            // Bar graph of quality on LEDs 1 to 4
            for (int unsigned i = 0; i < 4; i++)
            begin
               if (quality_lit(status.quality, i + 1))
               begin
                  diag_d[i] = make_led(led_status_pkg::LED_BLUE, 1'b0);
               end
            end
            if (status.top_sync)
            begin
               diag_d[4] = make_led(led_status_pkg::LED_BLUE, 1'b0);
               diag_d[5] = make_led(led_status_pkg::LED_BLUE, 1'b0);
            end
            if (status.bottom_sync)
            begin
               diag_d[6] = make_led(led_status_pkg::LED_BLUE, 1'b0);
               diag_d[7] = make_led(led_status_pkg::LED_BLUE, 1'b0);
            end
            if (status.quality == led_status_pkg::QUALITY_NONE)
            begin
               diag_d = '{default: make_led(led_status_pkg::LED_OFF, 1'b0)};
            end
         end

         // Warnings override single quality LEDs, and the feedback warning the output LED
         if (config_set.feedback_enabled && status.feedback_warning)
         begin
            output_d  = make_led(led_status_pkg::LED_RED, 1'b0);
            diag_d[0] = make_led(led_status_pkg::LED_YELLOW, flash_phase);
         end
         if (status.reset_button_fault)
         begin
            diag_d[3] = make_led(led_status_pkg::LED_YELLOW, flash_phase);
         end

         // Configuration states win over output and field LEDs; factory reset clears diag LEDs too
         if (status.config_mode)
         begin
            output_d = make_led(led_status_pkg::LED_RED, 1'b0);
            field_d  = make_led(led_status_pkg::LED_GREEN, flash_phase);
         end
         if (status.factory_reset)
         begin
            output_d = make_led(led_status_pkg::LED_RED, 1'b0);
            field_d  = make_led(led_status_pkg::LED_YELLOW_GREEN, 1'b0);
            diag_d   = '{default: make_led(led_status_pkg::LED_OFF, 1'b0)};
         end
      end
   end

   // Sender state LED source
   always_comb
   begin
      if (phase_q == PHASE_LAMP_TEST)
      begin
         state_d = make_led(led_status_pkg::LED_WHITE, 1'b0);
      end
      else if (sender_cabled)
      begin
         state_d = output_d;
      end
      else if (sender_running && !sender_fault)
      begin
         state_d = make_led(led_status_pkg::LED_YELLOW, 1'b0);
      end
      else
      begin
         state_d = make_led(led_status_pkg::LED_OFF, 1'b0);
      end
   end

   // Receiver outputs registered; flash flag carries the blink phase
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         diag_led   <= '{default: make_led(led_status_pkg::LED_OFF, 1'b0)};
         output_led <= make_led(led_status_pkg::LED_RED, 1'b0);
         field_led  <= make_led(led_status_pkg::LED_OFF, 1'b0);
      end
      else
      begin
         diag_led   <= diag_d;
         output_led <= output_d;
         field_led  <= field_d;
      end
   end

   // Sender outputs registered; uncabled sender shows only its state LED outside the lamp test
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         sender_diag_led  <= '{default: make_led(led_status_pkg::LED_OFF, 1'b0)};
         sender_state_led <= make_led(led_status_pkg::LED_OFF, 1'b0);
         sender_field_led <= make_led(led_status_pkg::LED_OFF, 1'b0);
      end
      else
      begin
         sender_state_led <= state_d;
         if (sender_cabled || phase_q == PHASE_LAMP_TEST)
         begin
            sender_diag_led  <= diag_d;
            sender_field_led <= field_d;
         end
         else
         begin
            sender_diag_led  <= '{default: make_led(led_status_pkg::LED_OFF, 1'b0)};
            sender_field_led <= make_led(led_status_pkg::LED_OFF, 1'b0);
         end
      end
   end

endmodule : led_status_indicator

//--- sim/led_status_indicator_props.sv
// Checker for the LED status indicator ports
`timescale 1ns/1ps
module led_status_indicator_props
#(
   parameter int unsigned LAMP_TEST   = 5,
   parameter int unsigned CONFIG_SHOW = 10
)
(
   input wire logic                          clock,
   input wire logic                          srst,
   input wire led_status_pkg::status_type    status,
   input wire led_status_pkg::config_type    config_set,
   input wire logic                          sender_cabled,
   input wire led_status_pkg::led_type [7:0] diag_led,
   input wire led_status_pkg::led_type       output_led,
   input wire led_status_pkg::led_type       field_led,
   input wire led_status_pkg::led_type [7:0] sender_diag_led,
   input wire led_status_pkg::led_type       sender_state_led,
   input wire led_status_pkg::led_type       sender_field_led
);
   logic [7:0] up_q;
   logic       run;

   // Cycles since reset
   always_ff @(posedge clock)
   begin
      if (srst)
         up_q <= 8'h00;
      else if (up_q != 8'hff)
         up_q <= up_q + 8'h01;
   end
   assign run = (up_q > LAMP_TEST + CONFIG_SHOW + 3); // Margin, phase edges not exact

   // Alignment bar on LEDs 1 to 4
   function automatic logic bar_ok(input led_status_pkg::led_type [7:0] d,
                                   input logic [2:0] q);
      bar_ok = 1'b1;
      for (int i = 0; i < 4; i++)
         if (d[i].colour != ((q > i) ? led_status_pkg::LED_BLUE : led_status_pkg::LED_OFF))
            bar_ok = 1'b0;
   endfunction : bar_ok

   // All eight diagnostic LEDs dark
   function automatic logic all_off(input led_status_pkg::led_type [7:0] d);
      all_off = 1'b1;
      for (int i = 0; i < 8; i++)
         if (d[i].colour != led_status_pkg::LED_OFF)
            all_off = 1'b0;
   endfunction : all_off

   default clocking main_cb @(posedge clock);
   endclocking
   default disable iff (srst);

   // Lamp test lights receiver and sender
   sequence lamp_on;
      diag_led[7].colour == led_status_pkg::LED_WHITE
         && sender_state_led.colour == led_status_pkg::LED_WHITE;
   endsequence
   // Only the bar decides LEDs 1 to 4; field blocked keeps the display on
   sequence bar_only;
      run && !status.field_clear && !status.feedback_warning
         && !status.reset_button_fault && !status.factory_reset && $stable(status.quality);
   endsequence

   AST_LAMP_TEST:
      assert property ($fell(srst) |-> ##[1:3] lamp_on)
      else $error("lamp test not shown after reset");
   AST_NO_SYNC:
      assert property (run && status.quality == led_status_pkg::QUALITY_NONE
         && !status.top_sync && !status.bottom_sync && !status.feedback_warning
         && !status.reset_button_fault |=> all_off(diag_led))
      else $error("diagnostic LEDs lit without sync");
   AST_QUALITY_BAR:
      assert property (bar_only [*3] |=> bar_ok(diag_led, $past(status.quality)))
      else $error("alignment bar wrong");
   AST_SYNC_PAIRS:
      assert property (run && !status.factory_reset && !status.field_clear
         && !$past(status.field_clear) && status.quality != led_status_pkg::QUALITY_NONE |=>
         diag_led[4] == diag_led[5] && diag_led[6] == diag_led[7]
         && (diag_led[4].colour == led_status_pkg::LED_BLUE) == $past(status.top_sync)
         && (diag_led[6].colour == led_status_pkg::LED_BLUE) == $past(status.bottom_sync))
      else $error("beam sync pair wrong");
   AST_FEEDBACK:
      assert property (run && status.feedback_warning && config_set.feedback_enabled
         && !status.factory_reset |=> diag_led[0].colour == led_status_pkg::LED_YELLOW
         && output_led.colour == led_status_pkg::LED_RED)
      else $error("feedback warning not shown");
   AST_BUTTON_FAULT:
      assert property (run && status.reset_button_fault && !status.factory_reset
         |=> diag_led[3].colour == led_status_pkg::LED_YELLOW)
      else $error("button fault not shown");
   AST_FACTORY:
      assert property (run && status.factory_reset |=> all_off(diag_led)
         && output_led.colour == led_status_pkg::LED_RED
         && field_led.colour == led_status_pkg::LED_YELLOW_GREEN)
      else $error("factory reset indication wrong");
   AST_FIELD_RED:
      assert property (run && (!status.field_clear || status.reset_pressed)
         && !status.alignment_aid_on && !status.config_mode && !status.factory_reset
         |=> field_led.colour == led_status_pkg::LED_RED)
      else $error("field LED not red");
   AST_MIRROR:
      assert property ((run && sender_cabled && $stable(status)) [*2] |=>
         sender_state_led == output_led && sender_diag_led == diag_led
         && sender_field_led == field_led)
      else $error("sender does not mirror receiver");
endmodule : led_status_indicator_props

bind led_status_indicator led_status_indicator_props
#(.LAMP_TEST(LAMP_TEST), .CONFIG_SHOW(CONFIG_SHOW))
props_inst
(
   .clock, .srst, .status, .config_set, .sender_cabled, .diag_led, .output_led, .field_led,
   .sender_diag_led, .sender_state_led, .sender_field_led
);

//--- sim/sender_model.sv
// Behavioural sender unit: boots after power-up, faults on command
`timescale 1ns/1ps
module sender_model
(
   input  wire logic clock,
   input  wire logic srst,
   input  wire logic break_unit,
   output logic      sender_running,
   output logic      sender_fault
);
   // Up one cycle after reset lets go; fault held while commanded
   always_ff @(posedge clock)
      sender_running <= !srst;
   assign sender_fault = break_unit;
endmodule : sender_model

//--- sim/tb.sv
// Self-checking bench for the LED status indicator
`timescale 1ns/1ps
module tb;
   localparam int unsigned FLASH_HALF  = 4;
   localparam int unsigned DISPLAY_OFF = 20;
   // Expected colours
   localparam led_status_pkg::led_colour_type OFF = led_status_pkg::LED_OFF,
      BLUE = led_status_pkg::LED_BLUE, WHITE = led_status_pkg::LED_WHITE,
      RED = led_status_pkg::LED_RED, GREEN = led_status_pkg::LED_GREEN,
      YELLOW = led_status_pkg::LED_YELLOW;

   logic                          clock;
   logic                          srst;
   led_status_pkg::status_type    st;
   led_status_pkg::config_type    cfg;
   logic                          cabled;
   logic                          break_unit;
   logic                          running;
   logic                          fault;
   logic                          ph;
   led_status_pkg::led_type [7:0] diag;
   led_status_pkg::led_type [7:0] s_diag;
   led_status_pkg::led_type       out_l;
   led_status_pkg::led_type       fld;
   led_status_pkg::led_type       s_state;
   int                            mismatches;
   int                            check_count;

   led_status_indicator #(.FLASH_HALF(FLASH_HALF), .DISPLAY_OFF(DISPLAY_OFF),
      .ALIGN_LONG(30), .LAMP_TEST(5), .CONFIG_SHOW(10)) led_status_indicator_inst
   (
      .clock(clock), .srst(srst), .status(st), .config_set(cfg),
      .sender_cabled(cabled), .sender_running(running), .sender_fault(fault),
      .diag_led(diag), .output_led(out_l), .field_led(fld), .sender_diag_led(s_diag),
      .sender_state_led(s_state), .sender_field_led()
   );
   sender_model sender_model_inst
   (
      .clock(clock), .srst(srst), .break_unit(break_unit),
      .sender_running(running), .sender_fault(fault)
   );

   // 40 MHz clock
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // Let outputs settle past the sampling edge
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick

   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done

   // Hang guard, counted as a mismatch
   initial
   begin
      repeat (3000) @(posedge clock);
      mismatches++;
      test_done();
   end

   // Main sequence
   initial
   begin
      srst = 1'b1;
      st = '0;
      cfg = '1;
      cabled = 1'b0;
      break_unit = 1'b0;
      mismatches = 0;
      check_count = 0;
      tick(9);
      check("rst_out", out_l.colour, RED);
      @(posedge clock);
      srst <= 1'b0;
      tick(3);
      check("lamp", diag[7].colour, WHITE);
      check("lamp_s", s_state.colour, WHITE);
      tick(7);
      for (int i = 0; i < 4; i++)
         check("cfg", diag[i].colour == WHITE, i != 1);
      @(posedge clock);
      cfg <= '0;
      tick(12);
      // Quality levels with the field blocked keep the display on
      for (int q = 0; q < 5; q++)
      begin
         @(posedge clock);
         st.quality <= 3'(q);
         st.top_sync <= (q > 0);
         st.bottom_sync <= (q > 1);
         tick(4);
         for (int i = 0; i < 4; i++)
            check("bar", diag[i].colour, q > i ? BLUE : OFF);
         check("top", {diag[4].colour, diag[5].colour}, {2{q > 0 ? BLUE : OFF}});
         check("bot", {diag[6].colour, diag[7].colour}, {2{q > 1 ? BLUE : OFF}});
         check("fld", fld.colour, RED);
      end
      @(posedge clock);
      cfg.feedback_enabled <= 1'b1;
      st.feedback_warning <= 1'b1;
      tick(3);
      check("fb", diag[0].colour, YELLOW);
      check("fb_out", out_l.colour, RED);
      check("fb_bar", diag[3].colour, BLUE);
      ph = diag[0].flash;
      tick(FLASH_HALF);
      check("fb_flash", diag[0].flash, !ph);
      @(posedge clock);
      cfg.feedback_enabled <= 1'b0;
      tick(3);
      check("fb_unset", diag[0].colour, BLUE);
      @(posedge clock);
      st.feedback_warning <= 1'b0;
      st.reset_button_fault <= 1'b1;
      tick(3);
      check("btn", diag[3].colour, YELLOW);
      check("btn_bar", diag[0].colour, BLUE);
      @(posedge clock);
      st.reset_button_fault <= 1'b0;
      st.config_mode <= 1'b1;
      tick(3);
      check("cm_out", out_l.colour, RED);
      check("cm_fld", fld.colour, GREEN);
      @(posedge clock);
      st.factory_reset <= 1'b1;
      tick(3);
      check("fr_fld", fld.colour, led_status_pkg::LED_YELLOW_GREEN);
      check("fr_diag", {diag[0].colour, diag[4].colour}, 6'h00);
      @(posedge clock);
      st.factory_reset <= 1'b0;
      st.config_mode <= 1'b0;
      st.field_clear <= 1'b1;
      st.reset_required <= 1'b1;
      tick(3);
      check("req", fld.colour, YELLOW);
      @(posedge clock);
      st.reset_pressed <= 1'b1;
      tick(3);
      check("press", fld.colour, RED);
      @(posedge clock);
      st.reset_pressed <= 1'b0;
      st.reset_required <= 1'b0;
      tick(DISPLAY_OFF + 5);
      check("dsp_off", diag[0].colour, OFF);
      @(posedge clock);
      st.alignment_aid_on <= 1'b1;
      tick(4);
      check("aid", diag[0].colour, BLUE);
      check("aid_fld", {out_l.colour, fld.colour}, {RED, GREEN});
      @(posedge clock);
      st.alignment_aid_on <= 1'b0;
      tick(DISPLAY_OFF + 5);
      check("dsp_off2", diag[0].colour, OFF);
      @(posedge clock);
      st.contamination_rise <= 1'b1;
      tick(4);
      check("dirt", diag[0].colour, BLUE);
      @(posedge clock);
      cabled <= 1'b1;
      st.output_on <= 1'b1;
      tick(4);
      check("mir_s", s_state.colour, GREEN);
      check("mir_d", s_diag[4].colour, BLUE);
      @(posedge clock);
      cabled <= 1'b0;
      tick(3);
      check("alone", s_state.colour, YELLOW);
      @(posedge clock);
      break_unit <= 1'b1;
      cfg.feedback_enabled <= 1'b1;
      st.feedback_warning <= 1'b1;
      tick(3);
      check("alone_f", s_state.colour, OFF);
      // Power cycle clears the feedback warning
      @(posedge clock);
      srst <= 1'b1;
      st.feedback_warning <= 1'b0;
      tick(2);
      check("pwr", diag[0].colour, OFF);
      @(posedge clock);
      srst <= 1'b0;
      tick(4);
      test_done();
   end
endmodule : tb
